// ===== bench/catb_properties.sv
// checker: apb timing, irq and watchdog relations at the top ports
// assumes binding onto catb_top, one pclk domain
`default_nettype none
module catb_properties (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // status
  input wire logic        irq,
  input wire logic        wdog_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero wait states, answer only in the access cycle
  a_ready_access: assert property (
    psel && !penable |=> pready && penable)
    else $error("no answer in access cycle");
  a_ready_only: assert property (
    pready |-> $past(psel && !penable))
    else $error("answer outside access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // a refused read returns zero read data
  a_err_zero: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_map_ok: assert property (
    psel && !penable && paddr <= 8'h14 && paddr[1:0] == 2'b00
    |=> !pslverr)
    else $error("mapped address refused");
  // read data holds between transfers
  a_data_hold: assert property (!pready |-> $stable(prdata))
    else $error("read data moved while idle");
  // irq follows the sticky flag: falls on clear, holds otherwise
  a_irq_clear: assert property (
    psel && penable && pwrite && paddr == 8'h0c && pwdata[0]
    |-> ##[1:2] !irq)
    else $error("irq survives clear");
  a_irq_hold: assert property (
    irq && !(psel && pwrite) && !$past(psel && pwrite) |=> irq)
    else $error("irq dropped by itself");
  a_wdog_start: assert property (!$past(presetn) |-> wdog_active)
    else $error("watchdog off after reset");
  a_wdog_stay: assert property (!wdog_active |=> !wdog_active)
    else $error("watchdog re-enabled");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
  c_wdog: cover property ($fell(wdog_active));
endmodule : catb_properties
bind catb_top catb_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .wdog_active(wdog_active));
`default_nettype wire

// ===== bench/testbench.sv
// testbench: apb driven checks of the counter array timebase
// assumes catb_top, apb slave answering on pclk
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, wdog_active, t0_ovf, ext_count_in, osc_div8_in;
  logic        cpu_idle, lerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r2;
  int          n_mismatch, num_checks;
  int          ex[8] = '{10, 30, 10, 10, 120, 10, 0, 0};

  catb_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .t0_ovf(t0_ovf),
    .ext_count_in(ext_count_in), .osc_div8_in(osc_div8_in),
    .cpu_idle(cpu_idle), .irq(irq), .wdog_active(wdog_active));

  always #5 pclk = ~pclk;

  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one transfer; waits for pready, the watchdog bounds a hang
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // count window is loose: sync and write latency at both ends
  task automatic chkr(input logic [15:0] got, input int e);
    num_checks++;
    if ($isunknown(got) || int'(got) < e - 4 || int'(got) > e + 4) begin
      n_mismatch++;
      $display("[FAIL] %0t count %0d exp %0d", $time, got, e);
    end
  endtask

  function automatic logic [31:0] md(logic [2:0] s, logic ie, logic idl);
    return {24'h0, idl, 3'h0, s, ie};
  endfunction

  // main sequence
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    t0_ovf = 0;
    ext_count_in = 1;
    osc_div8_in = 1;
    cpu_idle = 0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, catb_pkg::ADDR_MODE, 0, rd);
    chk(rd, catb_pkg::MODE_RESET);
    apb(0, catb_pkg::ADDR_WDOG, 0, rd);
    chk(rd, 32'h1);
    wr(catb_pkg::ADDR_MODE, md(catb_pkg::SEL_SYS, 0, 0));
    apb(0, catb_pkg::ADDR_MODE, 0, rd);
    chk(rd, catb_pkg::MODE_RESET);
    apb(0, 8'h40, 0, rd);
    chk({rd[31:1], lerr}, 32'h1);
    wr(catb_pkg::ADDR_WDOG, 0);
    repeat (2) @(posedge pclk);
    chk(32'(wdog_active), 32'h0);
    // every select code over 120 cycles of mixed sources
    for (int s = 0; s < 8; s++) begin
      wr(catb_pkg::ADDR_MODE, md(3'h6, 0, 0));
      wr(catb_pkg::ADDR_LOW, 0);
      wr(catb_pkg::ADDR_HIGH, 0);
      wr(catb_pkg::ADDR_MODE, md(3'(s), 0, 0));
      for (int i = 0; i < 120; i++) begin
        @(posedge pclk);
        t0_ovf <= (i % 12 == 0);
        ext_count_in <= (i % 12 >= 6);
        osc_div8_in <= (i % 12 >= 6);
      end
      wr(catb_pkg::ADDR_MODE, md(3'h6, 0, 0));
      apb(0, catb_pkg::ADDR_LOW, 0, rd);
      apb(0, catb_pkg::ADDR_HIGH, 0, r2);
      chkr({r2[7:0], rd[7:0]}, ex[s]);
    end
    // snapshot on a stopped counter
    wr(catb_pkg::ADDR_HIGH, 32'hff);
    wr(catb_pkg::ADDR_LOW, 32'hfe);
    apb(0, catb_pkg::ADDR_LOW, 0, rd);
    chk(rd, 32'hfe);
    wr(catb_pkg::ADDR_HIGH, 32'h12);
    apb(0, catb_pkg::ADDR_HIGH, 0, rd);
    chk(rd, 32'hff);
    apb(0, catb_pkg::ADDR_LOW, 0, rd);
    apb(0, catb_pkg::ADDR_HIGH, 0, rd);
    chk(rd, 32'h12);
    // low byte read at 0xff on a running counter: the carry lands
    // between setup and access, the held high byte must not take it
    wr(catb_pkg::ADDR_LOW, 32'hff);
    wr(catb_pkg::ADDR_MODE, md(catb_pkg::SEL_SYS, 0, 0));
    apb(0, catb_pkg::ADDR_LOW, 0, rd);
    apb(0, catb_pkg::ADDR_HIGH, 0, r2);
    chk({r2[23:0], rd[7:0]}, 32'h12ff);
    wr(catb_pkg::ADDR_MODE, md(3'h6, 0, 0));
    wr(catb_pkg::ADDR_HIGH, 32'hff);
    wr(catb_pkg::ADDR_LOW, 32'hfe);
    // wrap, sticky flag and irq
    wr(catb_pkg::ADDR_MODE, md(catb_pkg::SEL_SYS, 1, 0));
    repeat (8) @(posedge pclk);
    apb(0, catb_pkg::ADDR_MODE, 0, rd);
    chk(rd, 32'h109);
    apb(0, catb_pkg::ADDR_STATUS, 0, rd);
    chk(rd, 32'h1);
    chk(32'(irq), 32'h0);
    wr(catb_pkg::ADDR_MASK, 1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    wr(catb_pkg::ADDR_MODE, 32'h109);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    wr(catb_pkg::ADDR_STATUS, 1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(0, catb_pkg::ADDR_MODE, 0, rd);
    chk(rd, 32'h9);
    // idle: frozen with the suspend bit, running without it
    cpu_idle <= 1'b1;
    wr(catb_pkg::ADDR_MODE, md(catb_pkg::SEL_SYS, 0, 1));
    apb(0, catb_pkg::ADDR_LOW, 0, rd);
    apb(0, catb_pkg::ADDR_LOW, 0, r2);
    chk(r2, rd);
    wr(catb_pkg::ADDR_MODE, md(catb_pkg::SEL_SYS, 0, 0));
    apb(0, catb_pkg::ADDR_LOW, 0, rd);
    apb(0, catb_pkg::ADDR_LOW, 0, r2);
    chk((r2 - rd) & 32'hff, 32'h3);
    cpu_idle <= 1'b0;
    // reset again in mid-run: watchdog mode returns, writes refused
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(wdog_active), 32'h1);
    apb(0, catb_pkg::ADDR_MODE, 0, rd);
    chk(rd, catb_pkg::MODE_RESET);
    wr(catb_pkg::ADDR_HIGH, 32'h80);
    apb(0, catb_pkg::ADDR_LOW, 0, rd);
    apb(0, catb_pkg::ADDR_HIGH, 0, rd);
    chk(rd, 32'h0);
    end_sim;
  end

  // hang guard, well beyond the some 1270 cycles needed
  initial begin
    #50000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
endmodule : testbench
`default_nettype wire

// ===== hdl/catb_pkg.sv
// package for the counter array timebase: register map, fields, constants
// assumes a 32-bit apb slave with one aligned word per register
`default_nettype none
package catb_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_LOW    = 8'h00;
  localparam logic [7:0] ADDR_HIGH   = 8'h04;
  localparam logic [7:0] ADDR_MODE   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_WDOG   = 8'h14;
  // mode register fields
  localparam int MODE_OVF_IE  = 0;
  localparam int MODE_SEL_LO  = 1;
  localparam int MODE_SEL_HI  = 3;
  localparam int MODE_IDLE    = 7;
  localparam int MODE_OVF     = 8;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  // status / mask fields
  localparam int ST_OVF       = 0;
  localparam int ST_WIDTH     = 1;
  // watchdog control field
  localparam int WD_ENABLE    = 0;
  // timebase select codes
  localparam logic [2:0] SEL_DIV12 = 3'h0;
  localparam logic [2:0] SEL_DIV4  = 3'h1;
  localparam logic [2:0] SEL_T0    = 3'h2;
  localparam logic [2:0] SEL_EXT   = 3'h3;
  localparam logic [2:0] SEL_SYS   = 3'h4;
  localparam logic [2:0] SEL_OSC8  = 3'h5;
  // divider figures
  localparam int DIV12 = 12;
  localparam int DIV4  = 4;
  localparam int OSC_DIV = 8;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage : catb_pkg
`default_nettype wire

// ===== hdl/catb_sync.sv
// two flop synchroniser for asynchronous levels
// assumes the input comes from another clock or a pin
`default_nettype none
module catb_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic meta_d;
  logic sync_d;
  // next values pass straight through
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end
  // first flop read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= meta_d;
      dout   <= sync_d;
    end
  end
endmodule : catb_sync
`default_nettype wire

// ===== hdl/catb_tick_if.sv
// interface carrying qualified ticks from the timebase to the counter
// assumes both ends on pclk
`default_nettype none
interface catb_tick_if;
  logic tick;   // one-cycle count enable
  logic [2:0] sel;
  modport src (output tick, input sel);
  modport dst (input tick, output sel);
endinterface : catb_tick_if
`default_nettype wire

// ===== hdl/catb_timebase.sv
// timebase selector: produces one-cycle ticks for the counter
// assumes ext inputs already synchronised to pclk
`default_nettype none
module catb_timebase (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // synchronised sources
  input  wire logic t0_ovf,
  input  wire logic ext_in_s,
  input  wire logic osc_div8_s,
  // tick out
  catb_tick_if.src  tb
);
  logic [3:0] div_q, div_d;
  logic       ext_q, ext_d;
  logic       osc_q, osc_d;
  logic       tick_c;
  // prescaler wraps at twelve; divide by four taken from its low bits
  always_comb begin
    div_d = (div_q == 4'(catb_pkg::DIV12 - 1)) ? 4'h0 : div_q + 4'h1;
    ext_d = ext_in_s;
    osc_d = osc_div8_s;
    case (tb.sel)
      catb_pkg::SEL_DIV12: tick_c = (div_q == 4'h0);
      catb_pkg::SEL_DIV4:  tick_c = (div_q[1:0] == 2'h0);
      catb_pkg::SEL_T0:    tick_c = t0_ovf;
      catb_pkg::SEL_EXT:   tick_c = ext_q & ~ext_in_s;
      catb_pkg::SEL_SYS:   tick_c = 1'b1;
      catb_pkg::SEL_OSC8:  tick_c = osc_q & ~osc_div8_s;
      default:             tick_c = 1'b0;  // reserved codes stop counting
    endcase
  end
  // twelve is a multiple of four, so div4 ticks evenly off the shared
  // prescaler; one counter serves both divided rates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q   <= 4'h0;
      ext_q   <= 1'b0;
      osc_q   <= 1'b0;
      tb.tick <= 1'b0;
    end else begin
      div_q   <= div_d;
      ext_q   <= ext_d;
      osc_q   <= osc_d;
      tb.tick <= tick_c;
    end
  end
endmodule : catb_timebase
`default_nettype wire

// ===== hdl/catb_top.sv
// counter array timebase: 16-bit counter, snapshot read, overflow irq
// assumes an apb master on pclk; ext pins asynchronous to pclk
//
// Our own choices: the register offsets and the APB slave port.
`default_nettype none
module catb_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // count sources
  input  wire logic        t0_ovf,
  input  wire logic        ext_count_in,
  input  wire logic        osc_div8_in,
  input  wire logic        cpu_idle,
  // status out
  output logic             irq,
  output logic             wdog_active
);
  catb_tick_if tb_if ();
  logic ext_s, osc_s;

  // asynchronous pins pass two flops
  catb_sync u_sync_ext (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (ext_count_in),
    .dout  (ext_s)
  );
  catb_sync u_sync_osc (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (osc_div8_in),
    .dout  (osc_s)
  );
  catb_timebase u_tb (
    .pclk       (pclk),
    .presetn    (presetn),
    .t0_ovf     (t0_ovf),
    .ext_in_s   (ext_s),
    .osc_div8_s (osc_s),
    .tb         (tb_if.src)
  );

  logic [15:0] cnt_q, cnt_d;
  logic [7:0]  snap_q, snap_d;
  logic [2:0]  sel_q, sel_d;
  logic        ie_q, ie_d;
  logic        idle_q, idle_d;
  logic        ovf_q, ovf_d;
  logic        mask_q, mask_d;
  logic        wd_q, wd_d;
  logic [31:0] rd_d;
  logic        wr, rd, wrap, adv, acc_ok;

  assign tb_if.sel = sel_q;

  // apb strobes: writes act in the access cycle, reads latch in setup
  always_comb begin
    wr = psel & penable & pwrite;
    rd = psel & ~penable & ~pwrite;
    acc_ok = (paddr == catb_pkg::ADDR_LOW)  ||
             (paddr == catb_pkg::ADDR_HIGH) ||
             (paddr == catb_pkg::ADDR_MODE) ||
             (paddr == catb_pkg::ADDR_STATUS) ||
             (paddr == catb_pkg::ADDR_MASK) ||
             (paddr == catb_pkg::ADDR_WDOG);
  end

  // counter: idle bit freezes during cpu idle, reads never touch it
  always_comb begin
    adv   = tb_if.tick & ~(idle_q & cpu_idle);
    wrap  = adv && (cnt_q == catb_pkg::CNT_MAX);
    cnt_d = cnt_q;
    if (adv) begin
      cnt_d = cnt_q + 16'h0001;
    end
    // counter writes refused while watchdog mode holds
    if (wr && !wd_q && paddr == catb_pkg::ADDR_LOW) begin
      cnt_d = {cnt_q[15:8], pwdata[7:0]};
    end
    if (wr && !wd_q && paddr == catb_pkg::ADDR_HIGH) begin
      cnt_d = {pwdata[7:0], cnt_q[7:0]};
    end
  end

  // snapshot of high byte, taken with the low byte in the setup cycle so
  // a carry between setup and access cannot split the pair
  always_comb begin
    snap_d = snap_q;
    if (rd && paddr == catb_pkg::ADDR_LOW) begin
      snap_d = cnt_q[15:8];
    end
  end

  // mode, flag and mask; hardware set wins over software clear
  always_comb begin
    sel_d  = sel_q;
    ie_d   = ie_q;
    idle_d = idle_q;
    ovf_d  = ovf_q;
    mask_d = mask_q;
    wd_d   = wd_q;
    if (wr && paddr == catb_pkg::ADDR_MODE && !wd_q) begin
      sel_d  = pwdata[catb_pkg::MODE_SEL_HI:catb_pkg::MODE_SEL_LO];
      ie_d   = pwdata[catb_pkg::MODE_OVF_IE];
      idle_d = pwdata[catb_pkg::MODE_IDLE];
      if (!pwdata[catb_pkg::MODE_OVF]) begin
        ovf_d = 1'b0;
      end
    end
    if (wr && paddr == catb_pkg::ADDR_STATUS &&
        pwdata[catb_pkg::ST_OVF]) begin
      ovf_d = 1'b0;
    end
    if (wr && paddr == catb_pkg::ADDR_MASK) begin
      mask_d = pwdata[catb_pkg::ST_OVF];
    end
    // watchdog may only be switched off by software
    if (wr && paddr == catb_pkg::ADDR_WDOG &&
        !pwdata[catb_pkg::WD_ENABLE]) begin
      wd_d = 1'b0;
    end
    if (wrap) begin
      ovf_d = 1'b1;
    end
  end

  // read mux; high byte comes from the snapshot
  always_comb begin
    rd_d = prdata;
    if (rd) begin
      rd_d = 32'h0000_0000;
      case (paddr)
        catb_pkg::ADDR_LOW:    rd_d = {24'h00_0000, cnt_q[7:0]};
        catb_pkg::ADDR_HIGH:   rd_d = {24'h00_0000, snap_q};
        catb_pkg::ADDR_MODE: begin
          rd_d[catb_pkg::MODE_OVF_IE] = ie_q;
          rd_d[catb_pkg::MODE_SEL_HI:catb_pkg::MODE_SEL_LO] = sel_q;
          rd_d[catb_pkg::MODE_IDLE] = idle_q;
          rd_d[catb_pkg::MODE_OVF] = ovf_q;
        end
        catb_pkg::ADDR_STATUS: rd_d[catb_pkg::ST_OVF] = ovf_q;
        catb_pkg::ADDR_MASK:   rd_d[catb_pkg::ST_OVF] = mask_q;
        catb_pkg::ADDR_WDOG:   rd_d[catb_pkg::WD_ENABLE] = wd_q;
        default:               rd_d = 32'h0000_0000;
      endcase
    end
  end

  // all state and outputs registered here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q       <= catb_pkg::CNT_ZERO;
      snap_q      <= 8'h00;
      sel_q       <= catb_pkg::SEL_DIV12;
      ie_q        <= 1'b0;
      idle_q      <= 1'b0;
      ovf_q       <= 1'b0;
      mask_q      <= 1'b0;
      wd_q        <= 1'b1;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      irq         <= 1'b0;
      wdog_active <= 1'b1;
    end else begin
      cnt_q       <= cnt_d;
      snap_q      <= snap_d;
      sel_q       <= sel_d;
      ie_q        <= ie_d;
      idle_q      <= idle_d;
      ovf_q       <= ovf_d;
      mask_q      <= mask_d;
      wd_q        <= wd_d;
      prdata      <= rd_d;
      pready      <= psel & ~penable;  // one wait-free access cycle
      pslverr     <= psel & ~penable & ~acc_ok;
      irq         <= ovf_d & ie_d & mask_d;
      wdog_active <= wd_d;
    end
  end
endmodule : catb_top
`default_nettype wire
